// ==== design/fast_sync_port.sv ====
// Fast synchronous serial port with rate generator and Wishbone registers
//
// How it works
// - The port moves words in full duplex, or in half duplex over an open-drain data line.
// - As master the port makes the shift clock, as slave it follows the clock from outside.
// - Word width, bit order, idle clock level and sampling phase are set in the control word.
// - Transmit and receive each have a two-word buffer so shifting goes on while words wait.
// - A 16-bit down-counter with a 16-bit reload sets the rate, apart from any timer.
// - The rate counter ticks at half the core clock and counts down.
// - The rate counter runs only while the global enable bit is set and stops when cleared.
// - Reading the rate register while enabled gives the live count.
// - Reading it while disabled gives the reload, which can only be written then.
// - The bit rate is the core clock over twice the reload plus two, for any reload above zero; a reload of zero gives a quarter of the core clock.
// - The framing and clock options cover the usual SPI modes.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module fast_sync_port (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [fast_sync_port_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Serial pins
	input  wire logic        sclk_i,
	output logic             sclk_o,
	output logic             sclk_oe_o,
	input  wire logic        select_n_i,
	input  wire logic        ser_data_i,
	output logic             ser_data_o,
	output logic             ser_data_oe_o
);
	import fast_sync_port_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [15:0]     ctrl_reg;
	logic [15:0]     reload_reg;
	logic            overrun_reg;
	logic            ack_reg;
	logic [31:0]     rdata_reg;
	shift_state_type state_reg;
	logic [15:0]     tx_shift_reg;
	logic [15:0]     rx_shift_reg;
	logic [15:0]     rx_word_reg;
	logic            rx_push_reg;
	logic [3:0]      bit_cnt_reg;
	logic            phase_reg;
	logic            sclk_reg;
	logic            sclk_oe_reg;
	logic            dout_reg;
	logic            dout_oe_reg;
	logic            sclk_prev_reg;

	logic            enable;
	logic            master;
	logic            cpol;
	logic            cpha;
	logic            lsb_first;
	logic            half_duplex;
	logic [3:0]      width_m1;
	logic            req;
	logic            hit_ctrl;
	logic            hit_rate;
	logic            hit_txd;
	logic            hit_rxd;
	logic            hit_stat;
	logic            wr_ok;
	logic [15:0]     wmask;
	logic [15:0]     rate_count;
	logic            rate_lead;
	logic            rate_mid;
	logic            selected;
	logic            edge_first;
	logic            edge_second;
	logic            start;
	logic            abort;
	logic [15:0]     tx_next;
	logic [15:0]     rx_next;
	logic [15:0]     status;

	word_stream_if   bus_tx ();
	word_stream_if   tx_out ();
	word_stream_if   rx_in ();
	word_stream_if   bus_rx ();

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Bit that goes out next for the given word layout
	function automatic logic pick_bit(input logic [15:0] w, input logic [3:0] m1,
		input logic lsb);
		if (lsb) begin
			pick_bit = w[0];
		end else begin
			pick_bit = w[m1];
		end
	endfunction

	// Moves a received word down to bit 0 for either order
	function automatic logic [15:0] align_rx(input logic [15:0] w, input logic [3:0] m1,
		input logic lsb);
		logic [15:0] mask;
		mask = ~(16'hFFFF << m1 << 1);
		if (lsb) begin
			align_rx = (w >> (4'hF - m1)) & mask;
		end else begin
			align_rx = w & mask;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Control decode

	assign enable      = ctrl_reg[CTRL_EN];
	assign master      = ctrl_reg[CTRL_MASTER];
	assign cpol        = ctrl_reg[CTRL_CPOL];
	assign cpha        = ctrl_reg[CTRL_CPHA];
	assign lsb_first   = ctrl_reg[CTRL_LSB];
	assign half_duplex = ctrl_reg[CTRL_HALF];
	// Widths below two bits are clamped; one-bit words are not framed
	assign width_m1    = (ctrl_reg[CTRL_WHI:CTRL_WLO] < WIDTH_M1_MIN) ? WIDTH_M1_MIN
		: ctrl_reg[CTRL_WHI:CTRL_WLO];

	////////////////////////////////////////////////////////////////////////////////
	// Register bus

	assign req      = cyc_i && stb_i && !ack_reg;
	assign hit_ctrl = (adr_i == OFS_CTRL);
	assign hit_rate = (adr_i == OFS_RATE);
	assign hit_txd  = (adr_i == OFS_TXD);
	assign hit_rxd  = (adr_i == OFS_RXD);
	assign hit_stat = (adr_i == OFS_STAT);
	assign wmask    = {{8{sel_i[1]}}, {8{sel_i[0]}}};
	assign wr_ok    = req && we_i;

	// A data write waits for room, stalling ack instead of dropping a word
	assign bus_tx.data  = dat_i[15:0];
	assign bus_tx.valid = wr_ok && hit_txd;
	assign bus_rx.ready = req && !we_i && hit_rxd;

	assign status = {12'h000, overrun_reg, (state_reg == SH_SHIFT), bus_rx.valid,
		!bus_tx.ready};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !(we_i && hit_txd && !bus_tx.ready);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= ZERO32;
		end else if (req && !we_i) begin
			rdata_reg <= ZERO32;
			if (hit_ctrl) begin
				rdata_reg[15:0] <= ctrl_reg;
			end
			if (hit_rate) begin
				rdata_reg[15:0] <= enable ? rate_count : reload_reg;
			end
			if (hit_rxd && bus_rx.valid) begin
				rdata_reg[15:0] <= bus_rx.data;
			end
			if (hit_stat) begin
				rdata_reg[15:0] <= status;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_ok && hit_ctrl) begin
			ctrl_reg <= (ctrl_reg & ~(wmask & CTRL_MASK)) | (dat_i[15:0] & wmask & CTRL_MASK);
		end
	end

	// Writes while enabled are ignored so the running count is never disturbed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reload_reg <= RATE_RESET;
		end else if (wr_ok && hit_rate && !enable) begin
			reload_reg <= (reload_reg & ~wmask) | (dat_i[15:0] & wmask);
		end
	end

	// A new overrun wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overrun_reg <= 1'b0;
		end else if (rx_in.valid && !rx_in.ready) begin
			overrun_reg <= 1'b1;
		end else if (wr_ok && hit_stat && sel_i[0] && dat_i[ST_OVR]) begin
			overrun_reg <= 1'b0;
		end
	end

	assign dat_o = rdata_reg;
	assign ack_o = ack_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Buffers and rate generator

	pair_buffer tx_buffer (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.fill  (bus_tx),
		.drain (tx_out)
	);

	pair_buffer rx_buffer (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.fill  (rx_in),
		.drain (bus_rx)
	);

	rate_down_counter rate_gen (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.run_i    (enable),
		.reload_i (reload_reg),
		.count_o  (rate_count),
		.lead_o   (rate_lead),
		.mid_o    (rate_mid)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock edges

	assign selected = !select_n_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_i;
		end
	end

	// First edge leaves the idle level, second returns to it
	always_comb begin
		if (master) begin
			edge_first  = rate_lead && !phase_reg;
			edge_second = rate_mid && phase_reg;
		end else begin
			edge_first  = (sclk_i != sclk_prev_reg) && (sclk_i != cpol);
			edge_second = (sclk_i != sclk_prev_reg) && (sclk_i == cpol);
		end
	end

	// A slave sends zeros when nothing is queued
	assign start        = enable && (state_reg == SH_IDLE)
		&& (master ? tx_out.valid : selected);
	assign abort        = !enable || (!master && !selected);
	assign tx_out.ready = start;

	always_comb begin
		tx_next = lsb_first ? (tx_shift_reg >> 1) : (tx_shift_reg << 1);
		rx_next = lsb_first ? {ser_data_i, rx_shift_reg[15:1]}
			: {rx_shift_reg[14:0], ser_data_i};
	end

	assign rx_in.data  = rx_word_reg;
	assign rx_in.valid = rx_push_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Shifter

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= SH_IDLE;
			tx_shift_reg <= ZERO16;
			rx_shift_reg <= ZERO16;
			rx_word_reg  <= ZERO16;
			rx_push_reg  <= 1'b0;
			bit_cnt_reg  <= 4'h0;
			phase_reg    <= 1'b0;
			sclk_reg     <= 1'b0;
			dout_reg     <= 1'b0;
		end else begin
			rx_push_reg <= 1'b0;
			case (state_reg)
				SH_IDLE: begin
					sclk_reg    <= cpol;
					phase_reg   <= 1'b0;
					bit_cnt_reg <= 4'h0;
					if (start) begin
						state_reg    <= SH_SHIFT;
						tx_shift_reg <= tx_out.valid ? tx_out.data : ZERO16;
						dout_reg     <= tx_out.valid
							? pick_bit(tx_out.data, width_m1, lsb_first) : 1'b0;
					end
				end
				SH_SHIFT: begin
					if (abort) begin
						state_reg <= SH_IDLE;
					end else if (edge_first) begin
						sclk_reg  <= ~cpol;
						phase_reg <= 1'b1;
						if (!cpha) begin
							rx_shift_reg <= rx_next;
						end else if (bit_cnt_reg != 4'h0) begin
							tx_shift_reg <= tx_next;
							dout_reg     <= pick_bit(tx_next, width_m1, lsb_first);
						end
					end else if (edge_second) begin
						sclk_reg  <= cpol;
						phase_reg <= 1'b0;
						if (cpha) begin
							rx_shift_reg <= rx_next;
						end else begin
							tx_shift_reg <= tx_next;
							dout_reg     <= pick_bit(tx_next, width_m1, lsb_first);
						end
						if (bit_cnt_reg == width_m1) begin
							state_reg   <= SH_IDLE;
							rx_push_reg <= 1'b1;
							rx_word_reg <= align_rx(cpha ? rx_next : rx_shift_reg,
								width_m1, lsb_first);
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				default: begin
					state_reg <= SH_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers

	// Half duplex drives only low so several ends can share one line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_oe_reg <= 1'b0;
			dout_oe_reg <= 1'b0;
		end else begin
			sclk_oe_reg <= enable && master;
			dout_oe_reg <= enable && (master || selected)
				&& (!half_duplex || !dout_reg);
		end
	end

	assign sclk_o        = sclk_reg;
	assign sclk_oe_o     = sclk_oe_reg;
	assign ser_data_o    = dout_reg;
	assign ser_data_oe_o = dout_oe_reg;
endmodule

// ==== design/fast_sync_port_pkg.sv ====
// Shared constants and types of the fast synchronous port
package fast_sync_port_pkg;
	localparam int          DATA_W        = 16;
	localparam int          ADDR_W        = 8;
	localparam int          CLK_HZ        = 40000000;
	localparam int          RATE_PRESCALE = 2;
	// Byte offsets on the register bus
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_RATE      = 8'h04;
	localparam logic [7:0]  OFS_TXD       = 8'h08;
	localparam logic [7:0]  OFS_RXD       = 8'h0C;
	localparam logic [7:0]  OFS_STAT      = 8'h10;
	// Control fields
	localparam int          CTRL_EN       = 0;
	localparam int          CTRL_MASTER   = 1;
	localparam int          CTRL_CPOL     = 2;
	localparam int          CTRL_CPHA     = 3;
	localparam int          CTRL_LSB      = 4;
	localparam int          CTRL_HALF     = 5;
	localparam int          CTRL_WLO      = 8;
	localparam int          CTRL_WHI      = 11;
	localparam logic [15:0] CTRL_RESET    = 16'h0F00;
	localparam logic [15:0] CTRL_MASK     = 16'h0F3F;
	localparam logic [3:0]  WIDTH_M1_MIN  = 4'h1;
	// Status fields
	localparam int          ST_TXFULL     = 0;
	localparam int          ST_RXVALID    = 1;
	localparam int          ST_BUSY       = 2;
	localparam int          ST_OVR        = 3;
	localparam logic [15:0] RATE_RESET    = 16'h0001;
	localparam logic [15:0] ZERO16        = 16'h0000;
	localparam logic [31:0] ZERO32        = 32'h00000000;
	typedef enum {SH_IDLE, SH_SHIFT} shift_state_type;
endpackage

// ==== design/word_stream_if.sv ====
// Word stream with valid and ready between the port's modules
`timescale 1ns/10ps
interface word_stream_if;
	logic [15:0] data;
	logic        valid;
	logic        ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ==== design/rate_down_counter.sv ====
// Down-counting rate generator clocked at half the core clock
`timescale 1ns/10ps
module rate_down_counter (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Control
	input  wire logic        run_i,
	input  wire logic [15:0] reload_i,
	// State and events
	output logic      [15:0] count_o,
	output logic             lead_o,
	output logic             mid_o
);
	import fast_sync_port_pkg::*;

	logic        phase_reg;
	logic [16:0] span;

	// Half of reload plus one keeps mid apart from lead even at a reload of one
	assign span = {1'b0, reload_i} + 17'h00001;

	// Phase flop halves the core clock for the counter
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= ~phase_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= RATE_RESET;
		end else if (!run_i) begin
			count_o <= reload_i;
		end else if (phase_reg) begin
			if (count_o == ZERO16) begin
				count_o <= reload_i;
			end else begin
				count_o <= count_o - 16'h0001;
			end
		end
	end

	// Lead marks each bit start, mid the half-bit point
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			lead_o <= 1'b0;
			mid_o  <= 1'b0;
		end else begin
			lead_o <= phase_reg && (count_o == ZERO16);
			mid_o  <= phase_reg && (count_o == span[16:1]);
		end
	end
endmodule

// ==== design/pair_buffer.sv ====
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
module pair_buffer (
	// Clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// Streams
	word_stream_if.snk  fill,
	word_stream_if.src  drain
);
	import fast_sync_port_pkg::*;

	logic [15:0] slot_reg [2];
	logic [1:0]  used_reg;
	logic        push;
	logic        pop;

	assign fill.ready  = (used_reg != 2'h2);
	assign drain.valid = (used_reg != 2'h0);
	assign drain.data  = slot_reg[0];
	assign push        = fill.valid && fill.ready;
	assign pop         = drain.valid && drain.ready;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			used_reg <= 2'h0;
		end else begin
			used_reg <= used_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// Slot 0 is the head; slot 1 moves down on pop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_reg[0] <= ZERO16;
			slot_reg[1] <= ZERO16;
		end else begin
			if (pop) begin
				slot_reg[0] <= slot_reg[1];
			end
			if (push) begin
				if (used_reg == 2'h0 || (used_reg == 2'h1 && pop)) begin
					slot_reg[0] <= fill.data;
				end else begin
					slot_reg[1] <= fill.data;
				end
			end
		end
	end
endmodule

// ==== verif/fast_sync_port_asserts.sv ====
// Concurrent checks of the fast synchronous port, bound to its top module
`timescale 1ns/10ps
module fast_sync_port_asserts (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Register bus
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [fast_sync_port_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	// Serial pins
	input  wire logic        sclk_o,
	input  wire logic        sclk_oe_o,
	input  wire logic        ser_data_oe_o
);
	import fast_sync_port_pkg::*;
	logic        en_q;
	logic        master_q;
	logic [15:0] rate_q;
	logic [17:0] gap;
	logic        take_w;
	logic [17:0] period;
	assign take_w = cyc_i && stb_i && we_i && !ack_o;
	assign period = {1'b0, rate_q, 1'b0} + 18'h00002;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////
	// Shadow settings, taken on the same edge as the port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_q     <= CTRL_RESET[CTRL_EN];
			master_q <= CTRL_RESET[CTRL_MASTER];
			rate_q   <= RATE_RESET;
		end else if (take_w && adr_i == OFS_CTRL) begin
			en_q     <= dat_i[CTRL_EN];
			master_q <= dat_i[CTRL_MASTER];
		end else if (take_w && adr_i == OFS_RATE && !en_q) begin
			rate_q <= dat_i[15:0];
		end
	end
	// Cycles since the last rising shift clock, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i)
			gap <= 18'h3FFFF;
		else if ($rose(sclk_o))
			gap <= 18'h00001;
		else if (gap != 18'h3FFFF)
			gap <= gap + 18'h00001;
	end
	////////////////////////////////////////////////////////////
	property p_slave_quiet;
		!master_q |=> !sclk_oe_o;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet)
		else $error("shift clock driven outside master mode");
	property p_master_drives;
		(en_q && master_q) [*2] |-> sclk_oe_o;
	endproperty
	a_master_drives: assert property (p_master_drives)
		else $error("master does not drive its shift clock");
	property p_data_off;
		!en_q |=> !ser_data_oe_o;
	endproperty
	a_data_off: assert property (p_data_off)
		else $error("data line driven while disabled");
	property p_stop;
		(!en_q && !take_w) [*2] |=> !sclk_oe_o && $stable(sclk_o);
	endproperty
	a_stop: assert property (p_stop)
		else $error("shift clock moves while disabled");
	property p_rate_gap;
		$rose(sclk_o) |-> gap >= period;
	endproperty
	a_rate_gap: assert property (p_rate_gap)
		else $error("shift clock faster than the reload allows");
	property p_read_reload;
		ack_o && !we_i && adr_i == OFS_RATE && !en_q |-> dat_o[15:0] == rate_q;
	endproperty
	a_read_reload: assert property (p_read_reload)
		else $error("rate read while disabled is not the reload");
	property p_read_count;
		ack_o && !we_i && adr_i == OFS_RATE && en_q |-> dat_o[15:0] <= rate_q;
	endproperty
	a_read_count: assert property (p_read_count)
		else $error("live count above the reload");
	property p_upper_zero;
		ack_o && !we_i |-> dat_o[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("read data wider than 16 bits");
	c_rate_live: cover property (ack_o && adr_i == OFS_RATE && en_q);
	c_shift: cover property ($rose(sclk_o));
	c_data_out: cover property (ser_data_oe_o);
	c_slave_data: cover property (ser_data_oe_o && !master_q);
endmodule

bind fast_sync_port fast_sync_port_asserts u_fast_sync_port_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sclk_o(sclk_o),
	.sclk_oe_o(sclk_oe_o), .ser_data_oe_o(ser_data_oe_o));

// ==== verif/far_spi_device.sv ====
// Far-side peripheral model: clock-follower in mode 0 with a fixed reply
`timescale 1ns/10ps
module far_spi_device (
	// Shift clock and frame
	input  wire logic        sclk_i,
	input  wire logic        active_i,
	// Data
	input  wire logic        mosi_i,
	input  wire logic [15:0] reply_i,
	output logic             miso_o,
	output logic [15:0]      got_o
);
	logic [3:0] idx = 4'h0;
	initial got_o = 16'h0000;
	always @(posedge sclk_i) begin
		if (active_i)
			got_o <= {got_o[14:0], mosi_i};
	end
	// Next bit on the second edge; wraps after a 16-bit word
	always @(negedge sclk_i or negedge active_i) begin
		if (!active_i)
			idx <= 4'h0;
		else
			idx <= idx + 4'h1;
	end
	// Released line shows the inverse so a stale bit never passes
	assign miso_o = active_i ? reply_i[4'hF - idx] : ~reply_i[4'hF - idx];
endmodule

// ==== verif/fast_sync_port_test.sv ====
// Self-checking bench of the fast synchronous port
`timescale 1ns/10ps
module fast_sync_port_test;
	import fast_sync_port_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [31:0] dat_o;
	logic        ack_o, sclk_o, sclk_oe_o, ser_data_o, ser_data_oe_o;
	logic        sclk_in = 1'b1;
	logic        select_n = 1'b1;
	logic        mosi = 1'b0;
	logic        miso;
	logic [7:0]  sbyte;
	wire         ser_data_i;
	logic [15:0] reply = 16'h3C5A;
	logic [15:0] got;
	logic [31:0] rd;
	time         t0;
	int          mismatches = 0;
	int          comparisons = 0;

	always #12.5 clk_i = ~clk_i;

	// Bench plays the outside master while it holds the select low
	assign ser_data_i = select_n ? miso : mosi;

	fast_sync_port u_fast_sync_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .sclk_i(sclk_in), .sclk_o(sclk_o),
		.sclk_oe_o(sclk_oe_o), .select_n_i(select_n), .ser_data_i(ser_data_i),
		.ser_data_o(ser_data_o), .ser_data_oe_o(ser_data_oe_o));
	far_spi_device u_far_spi_device (.sclk_i(sclk_o), .active_i(sclk_oe_o),
		.mosi_i(ser_data_o), .reply_i(reply), .miso_o(miso), .got_o(got));
	////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One classic cycle; held until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h3;
		dat_i <= {16'h0000, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 16'h0000);
		chk(rd, e);
	endtask
	task automatic wait_rx();
		rd = ZERO32;
		for (int i = 0; i < 100 && rd[ST_RXVALID] !== 1'b1; i++) bus(1'b0, OFS_STAT, 16'h0000);
	endtask
	// Outside master, mode 3, lsb first, 8 bits; a bit lasts 8 clocks
	task automatic ext_master(input logic [7:0] tx, output logic [7:0] rx);
		select_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			sclk_in <= 1'b0;
			mosi <= tx[i];
			repeat (4) @(posedge clk_i);
			rx[i] = ser_data_o;
			sclk_in <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
		select_n <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(OFS_CTRL, {16'h0000, CTRL_RESET});
		rchk(OFS_RATE, {16'h0000, RATE_RESET});
		rchk(8'h20, ZERO32);
		bus(1'b1, OFS_RATE, 16'h0003);
		rchk(OFS_RATE, 32'h00000003);
		bus(1'b1, OFS_CTRL, 16'h0F03);
		bus(1'b0, OFS_RATE, 16'h0000);
		chk({31'h0, rd[15:0] <= 16'h0003}, 32'h00000001);
		bus(1'b1, OFS_TXD, 16'hA5C3);
		bus(1'b1, OFS_TXD, 16'h9E17);
		@(posedge sclk_o);
		t0 = $time;
		@(posedge sclk_o);
		chk(32'($time - t0), 32'h000000C8);
		wait_rx();
		rchk(OFS_RXD, {16'h0000, reply});
		wait_rx();
		rchk(OFS_RXD, {16'h0000, reply});
		chk({16'h0000, got}, 32'h00009E17);
		rchk(OFS_RXD, ZERO32);
		bus(1'b1, OFS_CTRL, 16'h0F00);
		rchk(OFS_RATE, 32'h00000003);
		chk({31'h0, sclk_oe_o}, ZERO32);
		bus(1'b1, OFS_CTRL, 16'h0F01);
		repeat (20) @(posedge clk_i);
		chk({31'h0, sclk_oe_o}, ZERO32);
		bus(1'b1, OFS_CTRL, 16'h071D);
		bus(1'b1, OFS_TXD, 16'h00A6);
		ext_master(8'h5C, sbyte);
		chk({24'h000000, sbyte}, 32'h000000A6);
		wait_rx();
		rchk(OFS_RXD, 32'h0000005C);
		final_report();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		final_report();
	end
endmodule
